/* File: cppm_top.sv */
`default_nettype none
module cppm_top #(
  parameter int SLEEP_CYCLES = cppm_pkg::SLEEP_CYC,
  parameter int CELL_HIGH_CYCLES = cppm_pkg::CELL_HIGH_CYC,
  parameter int CELL_LOW_CYCLES = cppm_pkg::CELL_LOW_CYC,
  parameter int OVERCURRENT_CYCLES = cppm_pkg::OVERCURRENT_CYC,
  parameter int SHORT_TRIP_CYCLES = cppm_pkg::SHORT_TRIP_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Qualified comparator inputs
  input wire logic host_data_line,
  input wire logic power_switch_input_n,
  input wire logic charger_detect,
  input wire logic cell_above_high,
  input wire logic cell_below_resume,
  input wire logic cell_below_low,
  input wire logic supply_below_3v,
  input wire logic supply_below_2v2,
  input wire logic sense_above_pos_oc,
  input wire logic sense_below_neg_oc,
  input wire logic sense_return_above_short,
  input wire logic pack_below_release,
  input wire logic pack_above_release,
  // Controls and status
  output logic charge_fet_control,
  output logic discharge_fet_control,
  output logic active_mode,
  output logic recovery_charge_enable,
  output logic probe_pull_down,
  output logic probe_pull_up,
  output logic cell_high_flag,
  output logic cell_depleted_flag,
  output logic charge_surge_flag,
  output logic discharge_surge_flag
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cppm_pkg::cppm_mode_t mode;
    logic [3:0] ctrl;
    logic [31:0] dl_cnt;
    logic [31:0] ch_cnt;
    logic [31:0] cl_cnt;
    logic [31:0] pc_cnt;
    logic [31:0] nc_cnt;
    logic [31:0] st_cnt;
    logic ch_flag;
    logic cl_flag;
    logic cs_flag;
    logic ds_flag;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic cc;
    logic dc;
    logic rc_en;
    logic pd;
    logic pu;
  } cppm_state_t;

  cppm_state_t state_reg, state_next;
  logic do_write, toggle_cmd, flag_clr;
  logic dl_trip, ch_trip, cl_trip, pc_trip, nc_trip, st_trip;
  logic wake, chg_block, dis_block;

  default clocking chk_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  function automatic logic [31:0] tick(input logic cond,
                                       input logic [31:0] cnt);
    // Counter saturates at all ones; limits are far below 2^32
    tick = 32'h0;
    if (cond) begin
      tick = (cnt == 32'hffffffff) ? cnt : cnt + 32'h1;
    end
  endfunction

  always_comb begin
    state_next = state_reg;
    // ----------------------------------------
    // Bus writes
    // ----------------------------------------
    if (s_axi_awvalid && !state_reg.aw_got) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_got) begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    do_write = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
    toggle_cmd = 1'b0;
    flag_clr = 1'b0;
    if (do_write) begin
      state_next.bvalid = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      if (state_reg.aw_addr == cppm_pkg::CTRL_ADDR && state_reg.w_strb[0]) begin
        state_next.ctrl = state_reg.w_data[3:0];
      end
      if (state_reg.aw_addr == cppm_pkg::CMD_ADDR && state_reg.w_strb[0]) begin
        toggle_cmd = state_reg.w_data[cppm_pkg::CMD_TOGGLE_BIT];
        flag_clr = state_reg.w_data[cppm_pkg::CMD_FLAGCLR_BIT];
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    // ----------------------------------------
    // Bus reads
    // ----------------------------------------
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      unique case (s_axi_araddr)
        cppm_pkg::CTRL_ADDR: state_next.rdata = {28'h0, state_reg.ctrl};
        cppm_pkg::STAT_ADDR: state_next.rdata = {24'h0, state_reg.pu,
          state_reg.pd, state_reg.mode, state_reg.ds_flag,
          state_reg.cs_flag, state_reg.cl_flag, state_reg.ch_flag,
          state_reg.rc_en};
        default: state_next.rdata = 32'h0;
      endcase
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    // ----------------------------------------
    // Delay timers, reset on drop and in sleep
    // ----------------------------------------
    state_next.dl_cnt = tick(state_reg.ctrl[cppm_pkg::CTRL_DSE_BIT] &&
      !host_data_line && state_reg.mode == cppm_pkg::CPPM_ACTIVE,
      state_reg.dl_cnt);
    state_next.ch_cnt = tick(cell_above_high &&
      state_reg.mode == cppm_pkg::CPPM_ACTIVE, state_reg.ch_cnt);
    state_next.cl_cnt = tick(cell_below_low &&
      state_reg.mode == cppm_pkg::CPPM_ACTIVE, state_reg.cl_cnt);
    state_next.pc_cnt = tick(sense_above_pos_oc &&
      state_reg.mode == cppm_pkg::CPPM_ACTIVE, state_reg.pc_cnt);
    state_next.nc_cnt = tick(sense_below_neg_oc &&
      state_reg.mode == cppm_pkg::CPPM_ACTIVE, state_reg.nc_cnt);
    state_next.st_cnt = tick(sense_return_above_short &&
      state_reg.mode == cppm_pkg::CPPM_ACTIVE, state_reg.st_cnt);
    dl_trip = state_reg.dl_cnt == 32'(SLEEP_CYCLES);
    ch_trip = state_reg.ch_cnt == 32'(CELL_HIGH_CYCLES);
    cl_trip = state_reg.cl_cnt == 32'(CELL_LOW_CYCLES);
    pc_trip = state_reg.pc_cnt == 32'(OVERCURRENT_CYCLES);
    nc_trip = state_reg.nc_cnt == 32'(OVERCURRENT_CYCLES);
    st_trip = state_reg.st_cnt == 32'(SHORT_TRIP_CYCLES);
    // ----------------------------------------
    // Protection flags, set wins over clear, except cell-high resume release wins over its set
    // ----------------------------------------
    if (flag_clr) begin
      state_next.ch_flag = 1'b0;
      state_next.cs_flag = 1'b0;
      state_next.ds_flag = 1'b0;
    end
    if (ch_trip) begin
      state_next.ch_flag = 1'b1;
    end
    if (state_reg.ch_flag && cell_below_resume) begin
      state_next.ch_flag = 1'b0;
    end
    if (pc_trip) begin
      state_next.cs_flag = 1'b1;
    end else if (state_reg.cs_flag && pack_below_release) begin
      state_next.cs_flag = 1'b0;
    end
    if (nc_trip || st_trip) begin
      state_next.ds_flag = 1'b1;
    end else if (state_reg.ds_flag && pack_above_release) begin
      state_next.ds_flag = 1'b0;
    end
    // ----------------------------------------
    // Mode
    // ----------------------------------------
    wake = !power_switch_input_n
      || (state_reg.ctrl[cppm_pkg::CTRL_DSE_BIT]
          && !state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT]
          && host_data_line)
      || (charger_detect
          && !state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT])
      || (toggle_cmd && state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT]);
    if (state_reg.mode == cppm_pkg::CPPM_ACTIVE) begin
      if (cl_trip) begin
        state_next.mode = cppm_pkg::CPPM_SLEEP;
        state_next.cl_flag = 1'b1;
      end else if (dl_trip) begin
        state_next.mode = cppm_pkg::CPPM_SLEEP;
      end else if (toggle_cmd
                   && state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT]) begin
        state_next.mode = cppm_pkg::CPPM_SLEEP;
      end
    end else if (state_reg.cl_flag) begin
      // Depleted cell: only a charger with supply above 2.2V releases
      if (charger_detect && !supply_below_2v2) begin
        state_next.cl_flag = 1'b0;
        state_next.mode = cppm_pkg::CPPM_ACTIVE;
      end
    end else if (wake) begin
      state_next.mode = cppm_pkg::CPPM_ACTIVE;
    end
    // ----------------------------------------
    // Outputs, high means FET off
    // ----------------------------------------
    chg_block = state_next.ch_flag || state_next.cl_flag ||
      state_next.cs_flag || !state_next.ctrl[cppm_pkg::CTRL_CAB_BIT] ||
      state_next.mode == cppm_pkg::CPPM_SLEEP;
    dis_block = state_next.cl_flag || state_next.cs_flag ||
      state_next.ds_flag || !state_next.ctrl[cppm_pkg::CTRL_DAB_BIT] ||
      state_next.mode == cppm_pkg::CPPM_SLEEP;
    state_next.cc = chg_block;
    state_next.dc = dis_block;
    state_next.rc_en = supply_below_3v;
    state_next.pd = state_next.cs_flag;
    state_next.pu = state_next.ds_flag;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.mode <= cppm_pkg::CPPM_SLEEP;
      state_reg.ctrl <= cppm_pkg::CTRL_RESET;
      state_reg.cc <= 1'b1;
      state_reg.dc <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign s_axi_awready = !state_reg.aw_got;
  assign s_axi_wready = !state_reg.w_got;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = 2'h0;
  assign charge_fet_control = state_reg.cc;
  assign discharge_fet_control = state_reg.dc;
  assign active_mode = state_reg.mode == cppm_pkg::CPPM_ACTIVE;
  assign recovery_charge_enable = state_reg.rc_en;
  assign probe_pull_down = state_reg.pd;
  assign probe_pull_up = state_reg.pu;
  assign cell_high_flag = state_reg.ch_flag;
  assign cell_depleted_flag = state_reg.cl_flag;
  assign charge_surge_flag = state_reg.cs_flag;
  assign discharge_surge_flag = state_reg.ds_flag;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence cl_trip_s;
    state_reg.mode == cppm_pkg::CPPM_ACTIVE && cl_trip;
  endsequence
  sequence asleep_s;
    !active_mode && !cell_depleted_flag;
  endsequence
  sleep_dc_a: assert property (
    !active_mode |-> discharge_fet_control && charge_fet_control)
    else $error("FET on in sleep");
  cell_low_a: assert property (
    cl_trip_s |=> !active_mode && cell_depleted_flag)
    else $error("cell low trip missed");
  cell_high_a: assert property (
    ch_trip && !cell_below_resume |=> charge_fet_control)
    else $error("cell high trip missed");
  high_keeps_dc_a: assert property (
    cell_high_flag && active_mode && !cell_depleted_flag &&
    !charge_surge_flag && !discharge_surge_flag &&
    state_reg.ctrl[cppm_pkg::CTRL_DAB_BIT] |-> !discharge_fet_control)
    else $error("discharge off on cell high");
  switch_wake_a: assert property (
    asleep_s ##0 !power_switch_input_n |=> active_mode)
    else $error("switch wake missed");
  host_wake_a: assert property (
    asleep_s ##0 (host_data_line && state_reg.ctrl[cppm_pkg::CTRL_DSE_BIT]
    && !state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT]) |=> active_mode)
    else $error("host line wake missed");
  charger_wake_a: assert property (
    asleep_s ##0 (charger_detect && !state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT])
    |=> active_mode)
    else $error("charger wake missed");
  toggle_wake_a: assert property (
    asleep_s ##0 (toggle_cmd && state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT])
    |=> active_mode)
    else $error("toggle wake missed");
  toggle_sleep_a: assert property (
    active_mode && toggle_cmd && state_reg.ctrl[cppm_pkg::CTRL_TCE_BIT]
    |=> !active_mode)
    else $error("toggle sleep missed");
  host_sleep_a: assert property (
    active_mode && dl_trip |=> !active_mode)
    else $error("disconnect sleep missed");
  deplete_exit_a: assert property (
    cell_depleted_flag && !active_mode && charger_detect && !supply_below_2v2
    |=> active_mode && !cell_depleted_flag)
    else $error("charger release missed");
  deplete_hold_a: assert property (
    cell_depleted_flag && supply_below_2v2 |=> cell_depleted_flag)
    else $error("depleted released at low supply");
  resume_a: assert property (
    cell_high_flag && cell_below_resume |=> !cell_high_flag)
    else $error("cell high not released");
  surge_fets_a: assert property (
    pc_trip |=> charge_fet_control && discharge_fet_control)
    else $error("charge surge left a FET on");
  surge_probe_a: assert property (
    pc_trip |=> charge_surge_flag && probe_pull_down)
    else $error("charge surge probe missing");
  dis_surge_a: assert property (
    nc_trip |=> discharge_surge_flag && probe_pull_up && discharge_fet_control)
    else $error("discharge surge missed");
  short_trip_a: assert property (
    st_trip |=> discharge_surge_flag && discharge_fet_control)
    else $error("short trip missed");
  recov_path_a: assert property (
    supply_below_3v |=> recovery_charge_enable)
    else $error("recovery path off");
  recov_off_a: assert property (
    !supply_below_3v |=> !recovery_charge_enable)
    else $error("recovery path left on");
  timer_clear_a: assert property (
    !sense_above_pos_oc |=> state_reg.pc_cnt == 32'h0)
    else $error("timer not restarted");
endmodule
`default_nettype wire

/* File: cppm_pkg.sv */
// Overview of operation
// - Data line low over 2s enters sleep
// - Toggle command while active disables pack, sleeps
// - Disconnect-sleep on, toggle off, line high wakes
// - Power switch low wakes device
// - Charger detect with toggle off wakes
// - Toggle command enabling pack wakes device
// - Reset starts in sleep
// - Measurement and protection only while active
// - Cell high past delay: charge off, flag
// - Charge resumes below resume threshold
// - Cell high leaves discharge on
// - Cell low past delay: both off, sleep
// - After cell low, charger attach wakes
// - Recovery charge only while supply below 3V
// - Cell low release waits supply above 2.2V
// - Charge overcurrent past delay: both off, flag
// - Charge surge: pull-down probe, release low
// - Discharge overcurrent: discharge off, pull-up probe
// - Short trip: discharge off, same release
// - FET controls are OR of causes
`default_nettype none
package cppm_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam logic [7:0] CMD_ADDR = 8'h08;
  localparam int CTRL_DSE_BIT = 0;
  localparam int CTRL_TCE_BIT = 1;
  localparam int CTRL_DAB_BIT = 2;
  localparam int CTRL_CAB_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'hc;
  localparam int CMD_TOGGLE_BIT = 0;
  localparam int CMD_FLAGCLR_BIT = 1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int SLEEP_MS = 2000;
  localparam longint SLEEP_CYC_L = longint'(SLEEP_MS) * CLK_HZ / 1000;
  localparam int SLEEP_CYC = int'(SLEEP_CYC_L);
  localparam int CELL_HIGH_CYC = 20000;
  localparam int CELL_LOW_CYC = 20000;
  localparam int OVERCURRENT_CYC = 200;
  localparam int SHORT_TRIP_CYC = 4;
  typedef enum logic {CPPM_SLEEP = 1'b0, CPPM_ACTIVE = 1'b1} cppm_mode_t;
endpackage
`default_nettype wire

/* File: cppm_cell_model.sv */
`default_nettype none
// ----------------------------------------
// Cell, pack and sense network as comparators
// ----------------------------------------
module cppm_cell_model #(
  parameter int HIGH_MV = 4300,
  parameter int RESUME_MV = 4100,
  parameter int LOW_MV = 2500,
  parameter int OC_MA = 100,
  parameter int SHORT_MV = 200,
  parameter int MARGIN_MV = 400
) (
  // Clock
  input wire logic aclk,
  // Analog levels set by the bench
  input var int cell_mv,
  input var int supply_mv,
  input var int sense_ma,
  input var int sns_mv,
  input var int pack_mv,
  // Comparator outputs
  output logic charger_detect,
  output logic cell_above_high,
  output logic cell_below_resume,
  output logic cell_below_low,
  output logic supply_below_3v,
  output logic supply_below_2v2,
  output logic sense_above_pos_oc,
  output logic sense_below_neg_oc,
  output logic sense_return_above_short,
  output logic pack_below_release,
  output logic pack_above_release
);
  // Comparators settle one cycle late, so no trip lands on the input edge
  always_ff @(posedge aclk) begin
    charger_detect <= pack_mv > cell_mv;
    cell_above_high <= cell_mv > HIGH_MV;
    cell_below_resume <= cell_mv < RESUME_MV;
    cell_below_low <= cell_mv < LOW_MV;
    supply_below_3v <= supply_mv < 3000;
    supply_below_2v2 <= supply_mv < 2200;
    sense_above_pos_oc <= sense_ma > OC_MA;
    sense_below_neg_oc <= sense_ma < -OC_MA;
    sense_return_above_short <= sns_mv > SHORT_MV;
    pack_below_release <= pack_mv < supply_mv - MARGIN_MV;
    pack_above_release <= pack_mv > supply_mv - MARGIN_MV;
  end
endmodule
`default_nettype wire

/* File: cppm_top_tb.sv */
`default_nettype none
module cppm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Short counts keep the run brief; expectations use the same values
  localparam int SC = 50, HC = 10, LC = 10, OC = 8, TC = 5;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, charger_detect, cell_above_high, cell_below_resume;
  logic host_data_line = 1'b1, power_switch_input_n = 1'b1;
  logic cell_below_low, supply_below_3v, supply_below_2v2;
  logic sense_above_pos_oc, sense_below_neg_oc, sense_return_above_short;
  logic pack_below_release, pack_above_release, charge_fet_control;
  logic discharge_fet_control, active_mode, recovery_charge_enable;
  logic probe_pull_down, probe_pull_up, cell_high_flag, cell_depleted_flag;
  logic charge_surge_flag, discharge_surge_flag;
  int cell_mv = 3700, supply_mv = 3700, sense_ma = 0, sns_mv = 0;
  int pack_mv = 3600, error_cnt = 0, samples_checked = 0;
  cppm_top #(.SLEEP_CYCLES(SC), .CELL_HIGH_CYCLES(HC), .CELL_LOW_CYCLES(LC),
    .OVERCURRENT_CYCLES(OC), .SHORT_TRIP_CYCLES(TC)) cppm_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_data_line, .power_switch_input_n, .charger_detect, .cell_above_high,
    .cell_below_resume, .cell_below_low, .supply_below_3v, .supply_below_2v2,
    .sense_above_pos_oc, .sense_below_neg_oc, .sense_return_above_short,
    .pack_below_release, .pack_above_release, .charge_fet_control,
    .discharge_fet_control, .active_mode, .recovery_charge_enable,
    .probe_pull_down, .probe_pull_up, .cell_high_flag, .cell_depleted_flag,
    .charge_surge_flag, .discharge_surge_flag);
  cppm_cell_model cppm_cell_model_inst (.aclk, .cell_mv, .supply_mv,
    .sense_ma, .sns_mv, .pack_mv, .charger_detect, .cell_above_high,
    .cell_below_resume, .cell_below_low, .supply_below_3v, .supply_below_2v2,
    .sense_above_pos_oc, .sense_below_neg_oc, .sense_return_above_short,
    .pack_below_release, .pack_above_release);
  always #25 aclk = ~aclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e);
    samples_checked++;
    if (rd_data !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, rd_data);
    end
  endtask
  task automatic chk_fet(input logic c, input logic d);
    chk_pin("charge_fet", c, charge_fet_control);
    chk_pin("discharge_fet", d, discharge_fet_control);
  endtask
  // Address and data go out together; each drops once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk_pin("bresp", 1'b0, |s_axi_bresp);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk_pin("rresp", 1'b0, |s_axi_rresp);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(3);
    aresetn <= 1'b1;
    cyc(2);
    chk_pin("active", 1'b0, active_mode);
    chk_fet(1'b1, 1'b1);
    rd(cppm_pkg::CTRL_ADDR);
    chk_reg("ctrl", {28'h0, cppm_pkg::CTRL_RESET});
    rd(8'h0c);
    chk_reg("unmapped", 32'h0);
    cell_mv <= 4400;
    cyc(HC + 6);
    chk_pin("high_flag", 1'b0, cell_high_flag);
    cell_mv <= 3700;
    power_switch_input_n <= 1'b0;
    cyc(4);
    power_switch_input_n <= 1'b1;
    cyc(2);
    chk_pin("active", 1'b1, active_mode);
    chk_fet(1'b0, 1'b0);
    rd(cppm_pkg::STAT_ADDR);
    chk_reg("stat", 32'h20);
    $display("reset and wake done");
    cell_mv <= 4400;
    cyc(HC - 2);
    cell_mv <= 3700;
    cyc(3);
    cell_mv <= 4400;
    cyc(HC - 2);
    chk_pin("high_flag", 1'b0, cell_high_flag);
    cyc(8);
    chk_pin("high_flag", 1'b1, cell_high_flag);
    chk_fet(1'b1, 1'b0);
    cell_mv <= 4000;
    cyc(6);
    chk_fet(1'b0, 1'b0);
    sense_ma <= 200;
    pack_mv <= 4500;
    cyc(OC + 6);
    chk_pin("chg_surge", 1'b1, charge_surge_flag);
    chk_fet(1'b1, 1'b1);
    chk_pin("pull_down", 1'b1, probe_pull_down);
    sense_ma <= 0;
    pack_mv <= 3000;
    cyc(6);
    chk_pin("charge_fet", 1'b0, charge_fet_control);
    wr(cppm_pkg::CMD_ADDR, 32'h2);
    pack_mv <= 1000;
    sense_ma <= -200;
    cyc(OC + 6);
    chk_pin("dis_surge", 1'b1, discharge_surge_flag);
    chk_pin("pull_up", 1'b1, probe_pull_up);
    chk_fet(1'b0, 1'b1);
    sense_ma <= 0;
    pack_mv <= 3600;
    cyc(6);
    chk_fet(1'b0, 1'b0);
    wr(cppm_pkg::CMD_ADDR, 32'h2);
    pack_mv <= 1000;
    sns_mv <= 300;
    cyc(TC + 6);
    chk_pin("dis_surge", 1'b1, discharge_surge_flag);
    chk_fet(1'b0, 1'b1);
    sns_mv <= 0;
    pack_mv <= 3600;
    cyc(6);
    chk_fet(1'b0, 1'b0);
    wr(cppm_pkg::CMD_ADDR, 32'h2);
    $display("protection done");
    wr(cppm_pkg::CTRL_ADDR, 32'h8);
    cyc(3);
    chk_fet(1'b0, 1'b1);
    wr(cppm_pkg::CTRL_ADDR, 32'h6);
    cyc(3);
    chk_fet(1'b1, 1'b0);
    wr(cppm_pkg::CTRL_ADDR, 32'he);
    wr(cppm_pkg::CMD_ADDR, 32'h1);
    cyc(3);
    chk_pin("active", 1'b0, active_mode);
    chk_fet(1'b1, 1'b1);
    wr(cppm_pkg::CMD_ADDR, 32'h1);
    cyc(3);
    chk_pin("active", 1'b1, active_mode);
    wr(cppm_pkg::CTRL_ADDR, 32'hd);
    host_data_line <= 1'b0;
    cyc(SC - 5);
    chk_pin("active", 1'b1, active_mode);
    cyc(12);
    chk_pin("active", 1'b0, active_mode);
    host_data_line <= 1'b1;
    cyc(5);
    chk_pin("active", 1'b1, active_mode);
    wr(cppm_pkg::CTRL_ADDR, 32'he);
    wr(cppm_pkg::CMD_ADDR, 32'h1);
    pack_mv <= 4500;
    cyc(4);
    chk_pin("active", 1'b0, active_mode);
    wr(cppm_pkg::CTRL_ADDR, 32'hc);
    cyc(3);
    chk_pin("active", 1'b1, active_mode);
    pack_mv <= 3600;
    $display("mode control done");
    cell_mv <= 2000;
    supply_mv <= 2000;
    cyc(LC + 6);
    chk_pin("depleted", 1'b1, cell_depleted_flag);
    chk_pin("active", 1'b0, active_mode);
    chk_fet(1'b1, 1'b1);
    chk_pin("recovery", 1'b1, recovery_charge_enable);
    cell_mv <= 3700;
    pack_mv <= 4500;
    cyc(6);
    chk_pin("active", 1'b0, active_mode);
    supply_mv <= 2500;
    cyc(6);
    chk_pin("active", 1'b1, active_mode);
    chk_pin("charge_fet", 1'b0, charge_fet_control);
    supply_mv <= 3700;
    cyc(4);
    chk_pin("recovery", 1'b0, recovery_charge_enable);
    $display("depletion done");
    end_sim();
  end
  // Whole run is well under two thousand cycles
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
